// File: src/aadp_top.sv
// Auxiliary converter decimation path with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "aadp_params.svh"
module aadp_top #(
    parameter int MOD_DIV = `AADP_MOD_DIV,
    parameter int FIFO_DEPTH = `AADP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mod_bit,
    output logic mod_strobe,
    output logic mod_enable,
    output logic [3:0] aux_positive_input_field,
    output logic [3:0] aux_negative_input_field,
    output logic [1:0] mod_gain_code,
    output logic amp_bypass,
    output logic [2:0] amp_gain_code,
    output logic [4:0] ref_select
);
    import aadp_pkg::*;

    localparam int ACC_W = 29;

    // Gain decode: modulator code 0..2 means x1, x2, x4
    function automatic logic [1:0] mod_gain_of(input logic [2:0] g);
        mod_gain_of = (g < 3'h3) ? g[1:0] : 2'h2; // R02 R03
    endfunction : mod_gain_of

    // Amplifier code n means gain 2^n, 0 when bypassed
    function automatic logic [2:0] amp_gain_of(input logic [2:0] g);
        amp_gain_of = (g < 3'h3) ? 3'h0 : g - 3'h2; // R01 R03
    endfunction : amp_gain_of

    function automatic logic [8:0] ratio_m1_of(input logic [1:0] r);
        unique case (r)
            `AADP_RATE_10, `AADP_RATE_100: ratio_m1_of = 9'h1ff; // R07
            `AADP_RATE_400: ratio_m1_of = 9'h07f; // R07
            `AADP_RATE_800: ratio_m1_of = 9'h03f; // R07
        endcase
    endfunction : ratio_m1_of

    function automatic logic signed [23:0] sat24(input logic signed [42:0] v);
        if (v > 43'sh7fffff)
        begin
            sat24 = 24'sh7fffff;
        end
        else if (v < -43'sh800000)
        begin
            sat24 = -24'sh800000;
        end
        else
        begin
            sat24 = v[23:0]; // R09
        end
    endfunction : sat24

    // Registers kept apart from any main converter settings
    logic [7:0] aux_converter_config; // R14
    logic [7:0] aux_input_select; // R11
    logic [15:0] cal_offset;
    logic [15:0] cal_fullscale;
    logic overrun;

    logic [7:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_ok;
    logic write_en;
    logic read_take;
    logic [7:0] ar_idx;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    aadp_state_t state;
    logic clr;
    logic begin_cmd;
    logic halt_cmd;
    logic cfg_change;
    logic [1:0] rate;

    logic [7:0] div_cnt;
    logic tick;
    logic [8:0] dec_cnt;
    logic signed [ACC_W-1:0] i1, i2, i3, d1, d2, d3;
    logic signed [ACC_W-1:0] next_c1, next_c2, next_c3;
    logic signed [42:0] next_scaled;
    logic s3_valid;
    logic signed [23:0] s3_data;
    logic [1:0] fill_cnt;
    logic [3:0] s1_cnt;
    logic signed [27:0] s1_sum;
    logic filt_valid;
    logic signed [23:0] filt_data;
    logic signed [42:0] next_cal;
    logic cal_valid;
    logic signed [23:0] cal_data;

    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [23:0] fifo_data;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;

    assign rate = aux_converter_config[`AADP_CFG_RATE_LSB +: 2];

    // AXI4-Lite write path: address and data taken in either order
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AADP_RESP_OKAY;
            aw_idx <= 8'h00;
            aw_ok <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_idx <= s_axi_awaddr[9:2];
                aw_ok <= (s_axi_awaddr[1:0] == 2'h0);
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_en)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_ok && aw_idx >= `AADP_IDX_CONFIG && aw_idx <= `AADP_IDX_STATUS)
                    ? `AADP_RESP_OKAY : `AADP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    assign write_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Command and settings decode for the converter sequence
    always_comb
    begin
        begin_cmd = 1'b0;
        halt_cmd = 1'b0;
        cfg_change = 1'b0;
        if (write_en && aw_ok && w_strb[0])
        begin
            begin_cmd = (aw_idx == `AADP_IDX_CTRL) && w_data[`AADP_CTRL_BEGIN]; // R15
            halt_cmd = (aw_idx == `AADP_IDX_CTRL) && w_data[`AADP_CTRL_HALT]; // R15
            cfg_change = (aw_idx == `AADP_IDX_CONFIG) || (aw_idx == `AADP_IDX_INSEL);
        end
    end

    // Begin, or a settings change while converting, restarts the filter
    assign clr = !halt_cmd && (begin_cmd || (cfg_change && state != AADP_IDLE)); // R16

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_converter_config <= `AADP_RST_CONFIG;
            aux_input_select <= `AADP_RST_INSEL;
            cal_offset <= `AADP_RST_OFS;
            cal_fullscale <= `AADP_RST_FS;
        end
        else if (write_en && aw_ok)
        begin
            if (aw_idx == `AADP_IDX_CONFIG && w_strb[0])
            begin
                aux_converter_config <= w_data[7:0];
            end
            if (aw_idx == `AADP_IDX_INSEL && w_strb[0])
            begin
                aux_input_select <= w_data[7:0]; // R11
            end
            for (int b = 0; b < 2; b++)
            begin
                if (aw_idx == `AADP_IDX_OFS && w_strb[b])
                begin
                    cal_offset[8*b +: 8] <= w_data[8*b +: 8];
                end
                if (aw_idx == `AADP_IDX_FS && w_strb[b])
                begin
                    cal_fullscale[8*b +: 8] <= w_data[8*b +: 8];
                end
            end
        end
    end

    // AXI4-Lite read path, data register pops the FIFO
    assign read_take = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[9:2];
    assign fifo_pop = read_take && (s_axi_araddr[1:0] == 2'h0)
        && (ar_idx == `AADP_IDX_DATA) && fifo_valid;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `AADP_RESP_OKAY;
        if (s_axi_araddr[1:0] != 2'h0)
        begin
            next_rresp = `AADP_RESP_SLVERR;
        end
        else
        begin
            unique case (ar_idx)
                `AADP_IDX_CONFIG: next_rdata[7:0] = aux_converter_config;
                `AADP_IDX_INSEL: next_rdata[7:0] = aux_input_select;
                `AADP_IDX_CTRL: next_rdata = 32'h0000_0000;
                `AADP_IDX_OFS: next_rdata[15:0] = cal_offset;
                `AADP_IDX_FS: next_rdata[15:0] = cal_fullscale;
                `AADP_IDX_STATUS: next_rdata = {23'h000000, fifo_level, 1'b0, overrun,
                    state == AADP_RUN, state != AADP_IDLE};
                `AADP_IDX_DATA: next_rdata[23:0] = fifo_valid ? fifo_data : 24'h000000;
                default: next_rresp = `AADP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AADP_RESP_OKAY;
        end
        else if (read_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Converter sequence: runs continuously from begin until halt
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= AADP_IDLE;
        end
        else if (halt_cmd)
        begin
            state <= AADP_IDLE; // R15
        end
        else if (clr)
        begin
            state <= AADP_FILL; // R16
        end
        else if (state == AADP_FILL && tick && dec_cnt == ratio_m1_of(rate)
            && fill_cnt == 2'(`AADP_SINC3_FILL))
        begin
            state <= AADP_RUN; // R16
        end
    end

    // Modulator sample strobe at clock divided by MOD_DIV
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end
        else if (clr || state == AADP_IDLE)
        begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end
        else if (div_cnt == 8'(MOD_DIV - 1))
        begin
            div_cnt <= 8'h00; // R04 R13
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 8'h01;
            tick <= 1'b0;
        end
    end

    // Sinc3 integrators at modulator rate, combs at the decimated rate
    always_comb
    begin
        next_c1 = i3 - d1;
        next_c2 = next_c1 - d2;
        next_c3 = next_c2 - d3;
        unique case (rate)
            `AADP_RATE_10, `AADP_RATE_100: next_scaled = 43'(next_c3 >>> 4); // R05
            `AADP_RATE_400: next_scaled = 43'(next_c3) <<< 2; // R05
            `AADP_RATE_800: next_scaled = 43'(next_c3) <<< 5; // R05
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {i1, i2, i3, d1, d2, d3} <= '0;
            dec_cnt <= 9'h000;
            fill_cnt <= 2'h0;
            s3_valid <= 1'b0;
            s3_data <= 24'sh000000;
        end
        else if (clr || state == AADP_IDLE)
        begin
            {i1, i2, i3, d1, d2, d3} <= '0; // R16
            dec_cnt <= 9'h000;
            fill_cnt <= 2'h0;
            s3_valid <= 1'b0;
        end
        else
        begin
            s3_valid <= 1'b0;
            if (tick)
            begin
                i1 <= i1 + (mod_bit ? ACC_W'(1) : -ACC_W'(1)); // R04
                i2 <= i2 + i1;
                i3 <= i3 + i2;
                if (dec_cnt == ratio_m1_of(rate))
                begin
                    dec_cnt <= 9'h000;
                    d1 <= i3;
                    d2 <= next_c1;
                    d3 <= next_c2;
                    if (state == AADP_FILL)
                    begin
                        fill_cnt <= fill_cnt + 2'h1; // R16
                    end
                    s3_valid <= (state == AADP_RUN);
                    s3_data <= sat24(next_scaled); // R09
                end
                else
                begin
                    dec_cnt <= dec_cnt + 9'h001;
                end
            end
        end
    end

    // Second stage: sinc1 by ten at 10 SPS, otherwise pass through
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_cnt <= 4'h0;
            s1_sum <= 28'sh0000000;
            filt_valid <= 1'b0;
            filt_data <= 24'sh000000;
        end
        else if (clr || state == AADP_IDLE)
        begin
            s1_cnt <= 4'h0;
            s1_sum <= 28'sh0000000;
            filt_valid <= 1'b0;
        end
        else
        begin
            filt_valid <= 1'b0;
            if (s3_valid && rate != `AADP_RATE_10)
            begin
                filt_valid <= 1'b1; // R06
                filt_data <= s3_data;
            end
            else if (s3_valid && s1_cnt == 4'(`AADP_SINC1_RATIO - 1))
            begin
                s1_cnt <= 4'h0; // R06 R08
                s1_sum <= 28'sh0000000;
                filt_valid <= 1'b1;
                filt_data <= sat24(((43'(s1_sum) + 43'(s3_data))
                    * $signed(43'(`AADP_RECIP10))) >>> `AADP_RECIP10_SHIFT);
            end
            else if (s3_valid)
            begin
                s1_cnt <= s1_cnt + 4'h1;
                s1_sum <= s1_sum + 28'(s3_data);
            end
        end
    end

    // Calibration: (raw - offset) * fullscale / 2^15
    assign next_cal = ((43'(filt_data) - 43'($signed(cal_offset)))
        * $signed(43'({1'b0, cal_fullscale}))) >>> `AADP_CAL_SHIFT; // R10

    // Result held while the FIFO is full; newer ones are lost
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_valid <= 1'b0;
            cal_data <= 24'sh000000;
        end
        else if (filt_valid && (!cal_valid || fifo_ready))
        begin
            cal_valid <= 1'b1;
            cal_data <= sat24(next_cal); // R10
        end
        else if (fifo_ready || clr)
        begin
            cal_valid <= 1'b0;
        end
    end

    // Overrun is sticky, write one to clear, a new event wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overrun <= 1'b0;
        end
        else if (filt_valid && cal_valid && !fifo_ready)
        begin
            overrun <= 1'b1;
        end
        else if (write_en && aw_ok && aw_idx == `AADP_IDX_STATUS && w_strb[0]
            && w_data[`AADP_STAT_OVERRUN])
        begin
            overrun <= 1'b0;
        end
    end

    aadp_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push_valid(cal_valid),
        .push_ready(fifo_ready),
        .push_data(cal_data),
        .pop_valid(fifo_valid),
        .pop_ready(fifo_pop),
        .pop_data(fifo_data),
        .level(fifo_level)
    );

    // Analog front-end controls, registered from converter state and settings
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_strobe <= 1'b0;
            mod_enable <= 1'b0;
            aux_positive_input_field <= 4'h0;
            aux_negative_input_field <= 4'h0;
            mod_gain_code <= 2'h0;
            amp_bypass <= 1'b1;
            amp_gain_code <= 3'h0;
            ref_select <= 5'h01;
        end
        else
        begin
            mod_strobe <= (state != AADP_IDLE) && !clr && div_cnt == 8'(MOD_DIV - 1);
            mod_enable <= (state != AADP_IDLE) && !clr;
            aux_positive_input_field <= aux_input_select[7:4]; // R11
            aux_negative_input_field <= aux_input_select[3:0]; // R11
            mod_gain_code <= mod_gain_of(aux_converter_config[`AADP_CFG_GAIN_LSB +: 3]);
            amp_bypass <= aux_converter_config[`AADP_CFG_GAIN_LSB +: 3] < 3'h3; // R02
            amp_gain_code <= amp_gain_of(aux_converter_config[`AADP_CFG_GAIN_LSB +: 3]);
            unique case (aux_converter_config[`AADP_CFG_REF_LSB +: 3])
                AADP_REF_PAIR01: ref_select <= 5'h01; // R12
                AADP_REF_PAIR23: ref_select <= 5'h02; // R12
                AADP_REF_PAIR45: ref_select <= 5'h04; // R12
                AADP_REF_SUPPLY: ref_select <= 5'h10; // R12
                default: ref_select <= 5'h08; // R12
            endcase
        end
    end
endmodule : aadp_top

// File: src/aadp_params.svh
// Constants for the auxiliary converter decimation path
// Behaviour
// R01 - Gain code 000..111 means gain 1..128
// R02 - Gains 1, 2, 4 bypass the amplifier
// R03 - Gains 8..128: modulator x4, amplifier the rest
// R04 - Modulator sampled at clock divided by 144
// R05 - Sinc3 stage decimates by 64, 128 or 512
// R06 - Extra sinc1 by ten only at 10 SPS
// R07 - Rate code 00/01/10/11 = 10/100/400/800 SPS
// R08 - Total ratio is first times second ratio
// R09 - Each result is a 24-bit word
// R10 - Results corrected by 16-bit offset, full-scale
// R11 - Input select holds positive and negative fields
// R12 - Reference: three pin pairs, internal, or supply
// R13 - All rates derive from and scale with clock
// R14 - Settings independent of the main converter
// R15 - Begin and halt commands bound continuous converting
// R16 - Start clears filter, withholds unsettled results
`ifndef AADP_PARAMS_SVH
`define AADP_PARAMS_SVH
// Register indices, byte address is four times the index
`define AADP_IDX_CONFIG 8'h15
`define AADP_IDX_INSEL 8'h16
`define AADP_IDX_CTRL 8'h17
`define AADP_IDX_OFS 8'h18
`define AADP_IDX_FS 8'h19
`define AADP_IDX_STATUS 8'h1a
`define AADP_IDX_DATA 8'h1b
// Field positions
`define AADP_CFG_RATE_LSB 0
`define AADP_CFG_GAIN_LSB 2
`define AADP_CFG_REF_LSB 5
`define AADP_CTRL_BEGIN 0
`define AADP_CTRL_HALT 1
`define AADP_STAT_OVERRUN 2
// Reset values
`define AADP_RST_CONFIG 8'h00
`define AADP_RST_INSEL 8'h01
`define AADP_RST_OFS 16'h0000
`define AADP_RST_FS 16'h8000
// Rate codes
`define AADP_RATE_10 2'h0
`define AADP_RATE_100 2'h1
`define AADP_RATE_400 2'h2
`define AADP_RATE_800 2'h3
// Timing and arithmetic
`define AADP_MOD_DIV 144
`define AADP_SINC1_RATIO 10
`define AADP_SINC3_FILL 2
`define AADP_RECIP10 15'h3333
`define AADP_RECIP10_SHIFT 17
`define AADP_CAL_SHIFT 15
`define AADP_FIFO_DEPTH 16
`define AADP_RESP_OKAY 2'h0
`define AADP_RESP_SLVERR 2'h2
`endif

// File: src/aadp_pkg.sv
// Types shared by the auxiliary converter decimation path
package aadp_pkg;
    // Gray coded along idle, fill, run
    typedef enum logic [1:0] {
        AADP_IDLE = 2'h0,
        AADP_FILL = 2'h1,
        AADP_RUN = 2'h3
    } aadp_state_t;
    // Reference selection codes
    typedef enum logic [2:0] {
        AADP_REF_PAIR01 = 3'h0,
        AADP_REF_PAIR23 = 3'h1,
        AADP_REF_PAIR45 = 3'h2,
        AADP_REF_INTERNAL = 3'h3,
        AADP_REF_SUPPLY = 3'h4
    } aadp_ref_t;
endpackage : aadp_pkg

// File: src/aadp_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/100ps
module aadp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [WIDTH-1:0] push_data,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WIDTH-1:0] pop_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    assign push_ready = (level != (AW+1)'(DEPTH));
    assign pop_valid = (level != '0);
    assign pop_data = mem[rd_ptr];
    assign do_push = push_valid && push_ready;
    assign do_pop = pop_valid && pop_ready;

    always_ff @(posedge clk_sys)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                level <= level + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                level <= level - 1'b1;
            end
        end
    end
endmodule : aadp_fifo

// File: dv/aadp_monitor.sv
// Port checker for the auxiliary decimation path
`timescale 1ns/100ps
module aadp_monitor #(
    parameter int MOD_DIV = 144
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mod_strobe,
    input wire logic mod_enable,
    input wire logic [1:0] mod_gain_code,
    input wire logic amp_bypass,
    input wire logic [2:0] amp_gain_code,
    input wire logic [4:0] ref_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] gap;
    // Cycles since the last strobe, zero until the first one
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n) gap <= '0;
        else if (!mod_enable) gap <= '0;
        else if (mod_strobe) gap <= 16'h1;
        else if (gap != 0) gap <= gap + 16'h1;
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
    AST_STROBE_GAP: assert property (mod_strobe && gap != 0 |-> gap == MOD_DIV)
        else $error("modulator strobe spacing wrong");
    AST_STROBE_EN: assert property (mod_strobe |-> mod_enable)
        else $error("strobe while not converting");
    AST_BYPASS: assert property (amp_bypass |-> amp_gain_code == 3'h0 && mod_gain_code <= 2'h2)
        else $error("bypassed gain split wrong");
    AST_AMP_ACTIVE: assert property (!amp_bypass |-> mod_gain_code == 2'h2 && amp_gain_code inside {[1:5]})
        else $error("amplifier gain split wrong");
    AST_REF_HOT: assert property ($onehot(ref_select))
        else $error("reference select not one-hot");
    AST_WR_ANS: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_B_DONE: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write response not retired");
    AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer not retired");
endmodule : aadp_monitor
bind aadp_top aadp_monitor #(.MOD_DIV(MOD_DIV)) mon_u (.*);

// File: dv/aadp_mod_src.sv
// Modulator bit source facing the decimation path
`timescale 1ns/100ps
module aadp_mod_src (
    input wire logic clk_sys,
    input wire logic mod_enable,
    input wire logic ones,
    output logic mod_bit = 1'b0
);
    // Toggles while idle so a stale bit never looks valid
    always @(posedge clk_sys)
    begin
        mod_bit <= mod_enable ? ones : ~mod_bit;
    end
endmodule : aadp_mod_src

// File: dv/aadp_top_tb.sv
// Self-checking bench for the auxiliary decimation path
`timescale 1ns/100ps
module aadp_top_tb;
    logic clk_sys = 1'b0;
    logic rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ones;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mod_bit;
    logic mod_strobe, mod_enable, amp_bypass;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, aux_positive_input_field, aux_negative_input_field;
    logic [1:0] s_axi_bresp, s_axi_rresp, mod_gain_code, r;
    logic [2:0] amp_gain_code;
    logic [4:0] ref_select;
    int fails, checks;
    aadp_top #(.MOD_DIV(4)) dut_u (.*);
    aadp_mod_src src_u (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic summarize;
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [9:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, d);
    endtask : rdc
    // Poll status until a masked bit is set
    task automatic wt(input logic [31:0] m);
        int n;
        n = 0;
        do
        begin
            rd(10'h068);
            n++;
        end
        while ((d & m) == 0 && n < 20000);
        chk("poll", 32'h0, 32'(n >= 20000));
    endtask : wt
    // Calibrated result for a constant bit stream
    function automatic logic [31:0] res(int rt, bit one);
        longint v;
        v = one ? 64'sh7fffff : -64'sh800000;
        if (rt == 0) v = (v * 10 * 64'sh3333) >>> 17;
        v = ((v - 64'sh10) * 64'sh4000) >>> 15;
        if (v > 64'sh7fffff) v = 64'sh7fffff;
        if (v < -64'sh800000) v = -64'sh800000;
        return {8'h00, v[23:0]};
    endfunction : res
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, ones, rst_n, fails, checks} = {4'hf, 1'b1, 1'b0, 64'h0};
        void'($urandom(32'h990d225b));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(10'h054, 32'h0, "config");
        rdc(10'h058, 32'h1, "insel");
        rdc(10'h064, 32'h8000, "fullscale");
        rd(10'h3fc);
        chk("unmapped", 32'h2, 32'(r));
        wr(10'h3fc, 32'h0);
        chk("wr_err", 32'h2, 32'(r));
        for (int g = 0; g < 8; g++)
        begin
            wr(10'h054, 32'(g << 5 | g << 2 | 3));
            repeat (2) @(posedge clk_sys);
            chk("bypass", 32'(g < 3), 32'(amp_bypass));
            chk("mod_gain", 32'(g < 3 ? g : 2), 32'(mod_gain_code));
            chk("amp_gain", 32'(g < 3 ? 0 : g - 2), 32'(amp_gain_code));
            chk("ref", 32'(1 << (g > 4 ? 3 : g)), 32'(ref_select));
        end
        wr(10'h058, {24'h0, 8'($urandom)});
        repeat (2) @(posedge clk_sys);
        chk("pos", 32'(s_axi_wdata[7:4]), 32'(aux_positive_input_field));
        chk("neg", 32'(s_axi_wdata[3:0]), 32'(aux_negative_input_field));
        wr(10'h060, 32'h10);
        wr(10'h064, 32'h4000);
        chk("wr_ok", 32'h0, 32'(r));
        for (int rt = 0; rt < 4; rt++)
        begin
            ones <= 1'(rt);
            wr(10'h054, 32'(rt) | 32'h40);
            wr(10'h05c, 32'h1);
            wt(32'h1f0);
            wr(10'h05c, 32'h2);
            rdc(10'h06c, res(rt, 1'(rt)), "result");
        end
        chk("enable", 32'h0, 32'(mod_enable));
        rdc(10'h06c, 32'h0, "empty");
        ones <= 1'b1;
        wr(10'h05c, 32'h1);
        wt(32'h4);
        wr(10'h05c, 32'h2);
        rd(10'h068);
        chk("level", 32'h10, 32'(d[8:4]));
        repeat (16) rdc(10'h06c, res(3, 1'b1), "drain");
        summarize;
    end
    initial
    begin
        #400000;
        fails++;
        summarize;
    end
endmodule : aadp_top_tb
